// ### hw/vrf_regs.svh
// Purpose: Shared constants of the vector register file
// Assumes: Included by bare name from the package and the design files
// Notes:   Definitions only
`ifndef VRF_REGS_SVH
`define VRF_REGS_SVH

`define VRF_NUM_REGS        16
`define VRF_NUM_REGS_NARROW 8
`define VRF_IDX_W           4
`define VRF_WIDE_W          256
`define VRF_HALF_W          128
`define VRF_LANE_W          32
`define VRF_ADDR_W          64
`define VRF_WIDE_ALIGN      6'h20
`define VRF_NARROW_ALIGN    6'h10
`define VRF_PENALTY_CYC     4

`endif

// ### hw/vrf_pkg.sv
// Purpose: Types of the vector register file
// Assumes: vrf_regs.svh supplies the widths
// Notes:   Nothing here is meant to be imported
`include "vrf_regs.svh"

package vrf_pkg;

  typedef enum logic [1:0] {
    CLS_LEGACY = 2'h0,
    CLS_NEW128 = 2'h1,
    CLS_NEW256 = 2'h2
  } vrf_class_type;

  typedef enum logic [2:0] {
    OP_MOVE  = 3'h0,
    OP_ADD   = 3'h1,
    OP_MUL   = 3'h2,
    OP_DIV   = 3'h3,
    OP_SQRT  = 3'h4,
    OP_BLEND = 3'h5,
    OP_WMUL  = 3'h6,
    OP_READ  = 3'h7
  } vrf_op_type;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_PEN  = 7'b0000010,
    S_READ = 7'b0000100,
    S_EXEC = 7'b0001000,
    S_HALF = 7'b0010000,
    S_WR   = 7'b0100000,
    S_WR2  = 7'b1000000
  } vrf_state_type;

  typedef struct packed {
    vrf_class_type              cls;
    vrf_op_type                 op;
    logic                       aligned;
    logic                       use_mem;
    logic [`VRF_IDX_W-1:0]      dst;
    logic [`VRF_IDX_W-1:0]      dst2;
    logic [`VRF_IDX_W-1:0]      src1;
    logic [`VRF_IDX_W-1:0]      src2;
    logic [`VRF_IDX_W-1:0]      src3;
    logic [`VRF_ADDR_W-1:0]     addr;
  } vrf_req_type;

  typedef struct packed {
    logic done;
    logic gp_fault;
    logic bad_reg;
  } vrf_resp_type;

endpackage

// ### hw/vrf_mem.sv
// Purpose: Register storage with split half write enables, three read ports
// Assumes: One clock; read data registered, one cycle after the address
// Notes:   Array itself has no reset; its contents are undefined until written
`include "vrf_regs.svh"

module vrf_mem #(
  parameter int DEPTH = `VRF_NUM_REGS,
  parameter int WIDTH = `VRF_WIDE_W
) (
  // Clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  // Write port
  input  wire logic                     i_we_lo,
  input  wire logic                     i_we_hi,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  // Read ports
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr_a,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr_b,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr_c,
  output logic      [WIDTH-1:0]         o_rdata_a,
  output logic      [WIDTH-1:0]         o_rdata_b,
  output logic      [WIDTH-1:0]         o_rdata_c
);

  localparam int HALF = WIDTH / 2;

  logic [WIDTH-1:0] store [DEPTH];

  // Narrow name is simply the low half of the same word
  always_ff @(posedge i_sys_clk)
  begin
    if (i_we_lo)
      store[i_waddr][HALF-1:0] <= i_wdata[HALF-1:0];
    if (i_we_hi)
      store[i_waddr][WIDTH-1:HALF] <= i_wdata[WIDTH-1:HALF];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata_a <= '0;
      o_rdata_b <= '0;
      o_rdata_c <= '0;
    end
    else
    begin
      o_rdata_a <= store[i_raddr_a];
      o_rdata_b <= store[i_raddr_b];
      o_rdata_c <= store[i_raddr_c];
    end
  end

endmodule

// ### hw/vrf_core.sv
// Purpose: Vector register file with class-based write-back and operand checks
// Assumes: One request at a time; ready is high only in the idle state
// Notes:   Integer 32-bit lanes stand in for the arithmetic datapath
`include "vrf_regs.svh"

module vrf_core #(
  parameter int NREGS   = `VRF_NUM_REGS,
  parameter int PEN_CYC = `VRF_PENALTY_CYC
) (
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  // Request from decode
  input  wire logic                  i_req_valid,
  input  wire vrf_pkg::vrf_req_type  i_req,
  input  wire logic [`VRF_WIDE_W-1:0] i_mem_data,
  input  wire logic                  i_mode64,
  // Response
  output logic                       o_req_ready,
  output vrf_pkg::vrf_resp_type      o_resp,
  output logic [`VRF_WIDE_W-1:0]     o_result,
  output logic                       o_penalty
);

  localparam int W  = `VRF_WIDE_W;
  localparam int H  = `VRF_HALF_W;
  localparam int L  = `VRF_LANE_W;
  localparam int IW = `VRF_IDX_W;

  function automatic logic reg_bad(input logic [IW-1:0] idx, input logic mode64);
    reg_bad = !mode64 && idx[IW-1];
  endfunction

  function automatic logic misaligned(input logic [5:0] a, input logic [5:0] bytes);
    misaligned = |(a & (bytes - 6'h01));
  endfunction

  function automatic logic [L-1:0] lane_sqrt(input logic [L-1:0] v);
    logic [L-1:0] rem;
    logic [L-1:0] root;
    logic [L-1:0] trial;
    rem  = v;
    root = '0;
    for (int i = L / 2 - 1; i >= 0; i--)
    begin
      trial = root | (L'(1) << i);
      if ((trial * trial) <= rem)
        root = trial;
    end
    lane_sqrt = root;
  endfunction

  vrf_pkg::vrf_state_type state_reg;
  vrf_pkg::vrf_state_type state_next;
  vrf_pkg::vrf_req_type   req_reg;
  vrf_pkg::vrf_resp_type  resp_next;
  logic [W-1:0]           mdata_reg;
  logic [W-1:0]           res_reg;
  logic [W-1:0]           res_next;
  logic                   dirty_reg;
  logic                   half_reg;
  logic [3:0]             pen_cnt_reg;

  // Intake checks on the incoming request
  wire in_legacy = i_req.cls == vrf_pkg::CLS_LEGACY;
  wire in_amove  = i_req.op == vrf_pkg::OP_MOVE && i_req.aligned;
  wire in_chk32  = i_req.use_mem && i_req.cls == vrf_pkg::CLS_NEW256 && in_amove;
  wire in_chk16  = i_req.use_mem
                   && (in_legacy || (i_req.cls == vrf_pkg::CLS_NEW128 && in_amove));
  // Other new-prefix memory forms are never checked
  wire in_gp     = (in_chk32 && misaligned(i_req.addr[5:0], `VRF_WIDE_ALIGN))
                   || (in_chk16 && misaligned(i_req.addr[5:0], `VRF_NARROW_ALIGN));
  // Upper eight indices are refused outside 64-bit mode
  wire in_bad    = reg_bad(i_req.dst, i_mode64)
                   || (!in_legacy && reg_bad(i_req.src1, i_mode64))
                   || (!i_req.use_mem && reg_bad(i_req.src2, i_mode64))
                   || (i_req.op == vrf_pkg::OP_BLEND && reg_bad(i_req.src3, i_mode64))
                   || (i_req.op == vrf_pkg::OP_WMUL && reg_bad(i_req.dst2, i_mode64));
  // Ready gates intake too, so the edge right after reset takes nothing
  wire accept    = state_reg == vrf_pkg::S_IDLE && o_req_ready && i_req_valid;

  // Latched request decode
  wire is_legacy = req_reg.cls == vrf_pkg::CLS_LEGACY;
  wire is_wide   = req_reg.cls == vrf_pkg::CLS_NEW256;
  wire is_wmul   = req_reg.op == vrf_pkg::OP_WMUL;
  wire is_split  = req_reg.op == vrf_pkg::OP_DIV || req_reg.op == vrf_pkg::OP_SQRT;

  // Legacy form reads its destination as first source
  wire [IW-1:0] idx_a = is_legacy ? req_reg.dst : req_reg.src1;

  logic [W-1:0] rd_a;
  logic [W-1:0] rd_b;
  logic [W-1:0] rd_c;
  logic [W-1:0] wdata;
  logic         we_lo;
  logic         we_hi;
  logic [IW-1:0] waddr;

  wire [W-1:0] opnd_a = rd_a;
  wire [W-1:0] opnd_b = req_reg.use_mem ? mdata_reg : rd_b;
  wire [W-1:0] opnd_c = rd_c;

  // Full-width lane units, one step for any length
  logic [W-1:0] add_w;
  logic [W-1:0] mul_w;
  logic [W-1:0] blend_w;
  logic [H-1:0] split_w;
  wire  [H-1:0] half_a = half_reg ? opnd_a[W-1:H] : opnd_a[H-1:0];
  wire  [H-1:0] half_b = half_reg ? opnd_b[W-1:H] : opnd_b[H-1:0];

  genvar g;
  generate
    for (g = 0; g < W / L; g++)
    begin : g_lane
      assign add_w[g*L +: L]   = opnd_a[g*L +: L] + opnd_b[g*L +: L];
      assign mul_w[g*L +: L]   = L'(opnd_a[g*L +: L] * opnd_b[g*L +: L]);
      // Selector's top bit per element picks the second source
      assign blend_w[g*L +: L] = opnd_c[g*L+L-1] ? opnd_b[g*L +: L] : opnd_a[g*L +: L];
    end
    // Divide and root exist only at half width, reused per half
    for (g = 0; g < H / L; g++)
    begin : g_half
      assign split_w[g*L +: L] = (req_reg.op == vrf_pkg::OP_SQRT) ? lane_sqrt(half_a[g*L +: L])
                                 : (half_b[g*L +: L] == '0) ? {L{1'b1}}
                                 : half_a[g*L +: L] / half_b[g*L +: L];
    end
  endgenerate

  // Flagless product of the low 64 bits; no flag port exists at all
  wire [H-1:0] wprod = opnd_a[63:0] * opnd_b[63:0];

  always_comb
  begin
    res_next = res_reg;
    if (state_reg == vrf_pkg::S_EXEC)
    begin
      case (req_reg.op)
        vrf_pkg::OP_ADD:   res_next = add_w;
        vrf_pkg::OP_MUL:   res_next = mul_w;
        vrf_pkg::OP_BLEND: res_next = blend_w;
        vrf_pkg::OP_WMUL:  res_next = {{H{1'b0}}, wprod};
        vrf_pkg::OP_DIV,
        vrf_pkg::OP_SQRT:  res_next = {res_reg[W-1:H], split_w};
        default:           res_next = opnd_b;
      endcase
    end
    else if (state_reg == vrf_pkg::S_HALF)
      res_next = {split_w, res_reg[H-1:0]};
  end

  // Write-back merge by class
  assign we_lo = (state_reg == vrf_pkg::S_WR && req_reg.op != vrf_pkg::OP_READ)
                 || state_reg == vrf_pkg::S_WR2;
  assign we_hi = we_lo && !is_legacy && !is_wmul;
  assign waddr = (state_reg == vrf_pkg::S_WR2) ? req_reg.dst2 : req_reg.dst;
  assign wdata[H-1:0] = !is_wmul ? res_reg[H-1:0]
                        : (state_reg == vrf_pkg::S_WR2) ? {64'h0, res_reg[H-1:64]}
                        : {64'h0, res_reg[63:0]};
  assign wdata[W-1:H] = is_wide ? res_reg[W-1:H] : '0;

  vrf_mem #(
    .DEPTH (NREGS),
    .WIDTH (W)
  ) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_we_lo   (we_lo),
    .i_we_hi   (we_hi),
    .i_waddr   (waddr),
    .i_wdata   (wdata),
    .i_raddr_a (idx_a),
    .i_raddr_b (req_reg.src2),
    .i_raddr_c (req_reg.src3),
    .o_rdata_a (rd_a),
    .o_rdata_b (rd_b),
    .o_rdata_c (rd_c)
  );

  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    resp_next  = '0;
    case (state_reg)
      vrf_pkg::S_IDLE:
        if (accept)
        begin
          if (in_bad || in_gp)
          begin
            resp_next.done     = 1'b1;
            resp_next.bad_reg  = in_bad;
            resp_next.gp_fault = in_gp && !in_bad;
          end
          else if (in_legacy && dirty_reg)
            state_next = vrf_pkg::S_PEN;
          else
            state_next = vrf_pkg::S_READ;
        end
      vrf_pkg::S_PEN:
        if (pen_cnt_reg == 4'h1)
          state_next = vrf_pkg::S_READ;
      vrf_pkg::S_READ:
        state_next = vrf_pkg::S_EXEC;
      vrf_pkg::S_EXEC:
        state_next = (is_split && is_wide) ? vrf_pkg::S_HALF : vrf_pkg::S_WR;
      vrf_pkg::S_HALF:
        state_next = vrf_pkg::S_WR;
      vrf_pkg::S_WR:
      begin
        state_next = is_wmul ? vrf_pkg::S_WR2 : vrf_pkg::S_IDLE;
        resp_next.done = !is_wmul;
      end
      vrf_pkg::S_WR2:
      begin
        state_next = vrf_pkg::S_IDLE;
        resp_next.done = 1'b1;
      end
      default:
        state_next = vrf_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg   <= vrf_pkg::S_IDLE;
      o_req_ready <= 1'b0;
      o_resp      <= '0;
      o_penalty   <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      o_req_ready <= state_next == vrf_pkg::S_IDLE;
      o_resp      <= resp_next;
      o_penalty   <= state_next == vrf_pkg::S_PEN;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      req_reg   <= '0;
      mdata_reg <= '0;
    end
    else if (accept)
    begin
      req_reg   <= i_req;
      mdata_reg <= i_mem_data;
    end
  end

  // Half select for the split units, low half first
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      half_reg <= 1'b0;
    else
      half_reg <= state_next == vrf_pkg::S_HALF;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      res_reg  <= '0;
      o_result <= '0;
    end
    else
    begin
      res_reg <= res_next;
      if (resp_next.done && state_reg != vrf_pkg::S_IDLE)
        o_result <= res_reg;
    end
  end

  // Upper-state tracking: wide write marks it, the penalty settles it
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      dirty_reg <= 1'b0;
    else if (state_reg == vrf_pkg::S_WR && is_wide && req_reg.op != vrf_pkg::OP_READ)
      dirty_reg <= 1'b1;
    else if (state_reg == vrf_pkg::S_PEN && pen_cnt_reg == 4'h1)
      dirty_reg <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      pen_cnt_reg <= '0;
    else if (accept)
      pen_cnt_reg <= 4'(PEN_CYC);
    else if (state_reg == vrf_pkg::S_PEN)
      pen_cnt_reg <= pen_cnt_reg - 4'h1;
  end

endmodule

// ### testbench/vrf_core_properties.sv
// Purpose: Port-level properties of the vector register file
// Assumes: Sees only the ports of vrf_core, one clock domain
// Notes:   Penalty length is counted, since repetition counts must be plain numbers
module vrf_core_props #(
  parameter int PEN_CYC = 4
) (
  input wire logic                  i_sys_clk,
  input wire logic                  i_rst,
  input wire logic                  i_req_valid,
  input wire vrf_pkg::vrf_req_type  i_req,
  input wire logic                  i_mode64,
  input wire logic                  o_req_ready,
  input wire vrf_pkg::vrf_resp_type o_resp,
  input wire logic [255:0]          o_result,
  input wire logic                  o_penalty
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  logic       take;
  logic [7:0] pen_cnt_reg;
  assign take = o_req_ready && i_req_valid;

  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      pen_cnt_reg <= 8'h0;
    else
      pen_cnt_reg <= o_penalty ? pen_cnt_reg + 8'h1 : 8'h0;

  a_ready_done_tie: assert property (take |=> o_req_ready == o_resp.done)
    else $error("ready does not follow completion");
  a_narrow_mode_refuse: assert property (take && !i_mode64 && i_req.dst[3]
    |=> o_resp.done && o_resp.bad_reg) else $error("upper index not refused");
  a_wide_add_timing: assert property (take && i_mode64 && i_req.cls == vrf_pkg::CLS_NEW256
    && i_req.op == vrf_pkg::OP_ADD |=> !o_resp.bad_reg ##3 o_resp.done)
    else $error("wide add timing wrong");
  a_wide_align_fault: assert property (take && i_mode64 && i_req.cls == vrf_pkg::CLS_NEW256
    && i_req.op == vrf_pkg::OP_MOVE && i_req.aligned && i_req.use_mem && i_req.addr[4:0] != 5'h0
    |=> o_resp.done && o_resp.gp_fault) else $error("misaligned wide move not faulted");
  a_legacy_align_fault: assert property (take && i_mode64 && i_req.cls == vrf_pkg::CLS_LEGACY
    && i_req.use_mem && i_req.addr[3:0] != 4'h0 |=> o_resp.gp_fault)
    else $error("misaligned legacy operand not faulted");
  a_loadop_no_fault: assert property (take && i_req.cls != vrf_pkg::CLS_LEGACY
    && i_req.op != vrf_pkg::OP_MOVE && i_req.use_mem |=> !o_resp.gp_fault)
    else $error("load-op faulted");
  a_penalty_len: assert property ($fell(o_penalty) |-> pen_cnt_reg == 8'(PEN_CYC))
    else $error("penalty length wrong");
  a_wide_div_halves: assert property (take && i_mode64 && i_req.cls == vrf_pkg::CLS_NEW256
    && i_req.op == vrf_pkg::OP_DIV |=> !o_resp.done [*4] ##1 o_resp.done)
    else $error("wide divide not in two halves");
  a_new_no_penalty: assert property (take && i_req.cls != vrf_pkg::CLS_LEGACY |=> !o_penalty)
    else $error("penalty on new-prefix op");
endmodule

bind vrf_core vrf_core_props #(.PEN_CYC(PEN_CYC)) u_props (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
  .i_mode64(i_mode64), .o_req_ready(o_req_ready), .o_resp(o_resp), .o_result(o_result),
  .o_penalty(o_penalty));

// ### testbench/vrf_mem_model.sv
// Purpose: Memory side of the decode pipeline, supplies operand data
// Assumes: Data depends only on the byte address
// Notes:   Lanes differ and alternate their top bit so lane swaps and blends show
module vrf_mem_model (
  // Address in
  input  wire logic [63:0]  i_addr,
  // Operand data out
  output logic      [255:0] o_mem_data
);
  timeunit 1ns;
  timeprecision 100ps;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      o_mem_data[32*i +: 32] = i_addr[31:0] * 32'(i + 3) + (32'(i % 2) << 31);
  end
endmodule

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the vector register file
// Assumes: Inputs change at the falling edge; one request in flight
// Notes:   Register contents are only compared after the bench has written them
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PEN = 4;
  logic                  clk = 1'b0;
  logic                  rst;
  logic                  valid;
  logic                  mode64;
  vrf_pkg::vrf_req_type  req;
  vrf_pkg::vrf_resp_type resp, resp_q;
  logic                  ready, penalty;
  logic [255:0]          mem_data, result, res_q, mem_q, x, y;
  int                    lat, pen_n, error_cnt = 0, n_tests = 0;

  always #25 clk = ~clk;

  vrf_mem_model u_mem (.i_addr(req.addr), .o_mem_data(mem_data));
  vrf_core #(.NREGS(16), .PEN_CYC(PEN)) dut (
    .i_sys_clk(clk), .i_rst(rst), .i_req_valid(valid), .i_req(req), .i_mem_data(mem_data),
    .i_mode64(mode64), .o_req_ready(ready), .o_resp(resp), .o_result(result), .o_penalty(penalty));

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [255:0] lanes(input vrf_pkg::vrf_op_type o,
                                         input logic [255:0] a, b, c);
    logic [255:0] r;
    logic [63:0]  q;
    r = '0;
    for (int i = 0; i < 8; i++)
      case (o)
        vrf_pkg::OP_ADD: r[32*i +: 32] = a[32*i +: 32] + b[32*i +: 32];
        vrf_pkg::OP_MUL: r[32*i +: 32] = a[32*i +: 32] * b[32*i +: 32];
        vrf_pkg::OP_SQRT:
        begin
          q = 64'h0;
          while ((q + 64'h1) * (q + 64'h1) <= 64'(a[32*i +: 32]))
            q++;
          r[32*i +: 32] = q[31:0];
        end
        vrf_pkg::OP_DIV: r[32*i +: 32] = a[32*i +: 32] / b[32*i +: 32];
        default:         r[32*i +: 32] = c[32*i+31] ? b[32*i +: 32] : a[32*i +: 32];
      endcase
    return r;
  endfunction

  // Request is held until the edge that takes it; completion bounded at 40 cycles
  task automatic do_op();
    @(negedge clk);
    while (ready !== 1'b1)
      @(negedge clk);
    valid = 1'b1;
    #1 mem_q = mem_data;
    @(negedge clk);
    valid = 1'b0;
    lat = 1;
    pen_n = 0;
    while (resp.done !== 1'b1 && lat < 40)
    begin
      pen_n += int'(penalty === 1'b1);
      @(negedge clk);
      lat++;
    end
    if (lat >= 40)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t no completion", $time);
    end
    resp_q = resp;
    res_q = result;
  endtask

  task automatic op(input vrf_pkg::vrf_class_type c, input vrf_pkg::vrf_op_type o,
                    input logic [3:0] d, s1, s2, input logic m, input logic [63:0] a);
    req = '0;
    req.cls = c;
    req.op = o;
    req.dst = d;
    req.src1 = s1;
    req.src2 = s2;
    req.use_mem = m;
    req.addr = a;
    do_op();
  endtask

  task automatic ld(input logic [3:0] r, input logic [63:0] a);
    op(vrf_pkg::CLS_NEW256, vrf_pkg::OP_MOVE, r, 4'h0, 4'h0, 1'b1, a);
  endtask

  task automatic rd(input logic [3:0] r, output logic [255:0] v);
    op(vrf_pkg::CLS_NEW256, vrf_pkg::OP_READ, 4'h0, 4'h0, r, 1'b0, 64'h0);
    v = res_q;
  endtask

  task automatic t_writeback();
    logic [255:0] a, b, v;
    ld(4'h1, 64'h40);
    a = mem_q;
    rd(4'h1, v);
    chk(v, a);
    op(vrf_pkg::CLS_LEGACY, vrf_pkg::OP_MOVE, 4'h1, 4'h0, 4'h0, 1'b1, 64'h80);
    b = mem_q;
    chk(256'(lat), 256'(4 + PEN));
    chk(256'(pen_n), 256'(PEN));
    rd(4'h1, v);
    chk(v, {a[255:128], b[127:0]});
    op(vrf_pkg::CLS_NEW128, vrf_pkg::OP_MOVE, 4'h1, 4'h0, 4'h0, 1'b1, 64'hc4);
    b = mem_q;
    rd(4'h1, v);
    chk(v, {128'h0, b[127:0]});
  endtask

  task automatic t_mode();
    logic [255:0] a, v;
    ld(4'h9, 64'h100);
    a = mem_q;
    mode64 = 1'b0;
    ld(4'h9, 64'h140);
    chk(256'(resp_q), 256'(3'b101));
    chk(256'(lat), 256'(1));
    ld(4'h7, 64'h140);
    chk(256'(resp_q), 256'(3'b100));
    mode64 = 1'b1;
    rd(4'h9, v);
    chk(v, a);
  endtask

  // Two memory accesses, aligned flag clear and then as given; expects done with the given fault flag after the second
  task automatic al(input vrf_pkg::vrf_class_type c, input vrf_pkg::vrf_op_type o,
                    input logic a, input logic [7:0] ad, input logic gp);
    op(c, o, 4'h9, 4'h9, 4'h0, 1'b1, {56'h0, ad});
    req.aligned = a;
    do_op();
    chk(256'(resp_q), 256'({1'b1, gp, 1'b0}));
  endtask

  task automatic t_align();
    al(vrf_pkg::CLS_NEW256, vrf_pkg::OP_MOVE, 1'b1, 8'h10, 1'b1);
    al(vrf_pkg::CLS_NEW256, vrf_pkg::OP_MOVE, 1'b1, 8'h20, 1'b0);
    al(vrf_pkg::CLS_NEW128, vrf_pkg::OP_MOVE, 1'b1, 8'h08, 1'b1);
    al(vrf_pkg::CLS_NEW256, vrf_pkg::OP_ADD, 1'b0, 8'h03, 1'b0);
    al(vrf_pkg::CLS_LEGACY, vrf_pkg::OP_ADD, 1'b0, 8'h08, 1'b1);
    al(vrf_pkg::CLS_LEGACY, vrf_pkg::OP_ADD, 1'b0, 8'h30, 1'b0);
  endtask

  task automatic t_wmul();
    logic [255:0] w5, w6, v;
    logic [127:0] p;
    ld(4'h2, 64'h48);
    x = mem_q;
    ld(4'h3, 64'h1c8);
    y = mem_q;
    ld(4'h5, 64'h60);
    w5 = mem_q;
    ld(4'h6, 64'ha0);
    w6 = mem_q;
    op(vrf_pkg::CLS_NEW256, vrf_pkg::OP_WMUL, 4'h5, 4'h2, 4'h3, 1'b0, 64'h0);
    req.dst2 = 4'h6;
    do_op();
    chk(256'(lat), 256'(5));
    p = 128'(x[63:0]) * 128'(y[63:0]);
    rd(4'h5, v);
    chk(v, {w5[255:128], 64'h0, p[63:0]});
    rd(4'h6, v);
    chk(v, {w6[255:128], 64'h0, p[127:64]});
  endtask

  task automatic t_arith();
    logic [255:0] v, s;
    op(vrf_pkg::CLS_NEW256, vrf_pkg::OP_ADD, 4'h7, 4'h2, 4'h3, 1'b0, 64'h0);
    chk(256'(lat), 256'(4));
    chk(res_q, lanes(vrf_pkg::OP_ADD, x, y, '0));
    rd(4'h2, v);
    chk(v, x);
    op(vrf_pkg::CLS_NEW256, vrf_pkg::OP_DIV, 4'h7, 4'h2, 4'h3, 1'b0, 64'h0);
    chk(256'(lat), 256'(5));
    chk(res_q, lanes(vrf_pkg::OP_DIV, x, y, '0));
    op(vrf_pkg::CLS_NEW256, vrf_pkg::OP_MUL, 4'h7, 4'h2, 4'h3, 1'b0, 64'h0);
    chk(256'(lat), 256'(4));
    chk(res_q, lanes(vrf_pkg::OP_MUL, x, y, '0));
    op(vrf_pkg::CLS_NEW256, vrf_pkg::OP_SQRT, 4'h7, 4'h2, 4'h3, 1'b0, 64'h0);
    chk(256'(lat), 256'(5));
    chk(res_q, lanes(vrf_pkg::OP_SQRT, x, y, '0));
    op(vrf_pkg::CLS_NEW128, vrf_pkg::OP_ADD, 4'h7, 4'h2, 4'h3, 1'b0, 64'h0);
    chk(256'(lat), 256'(4));
    op(vrf_pkg::CLS_NEW256, vrf_pkg::OP_BLEND, 4'h7, 4'h2, 4'h3, 1'b0, 64'h0);
    req.src3 = 4'h3;
    do_op();
    rd(4'h7, v);
    chk(v, lanes(vrf_pkg::OP_BLEND, x, y, y));
    op(vrf_pkg::CLS_LEGACY, vrf_pkg::OP_ADD, 4'h2, 4'hf, 4'h3, 1'b0, 64'h0);
    chk(256'(lat), 256'(4 + PEN));
    s = lanes(vrf_pkg::OP_ADD, x, y, '0);
    rd(4'h2, v);
    chk(v, {x[255:128], s[127:0]});
  endtask

  initial
  begin
    rst = 1'b1;
    valid = 1'b0;
    mode64 = 1'b1;
    req = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_writeback();
    t_mode();
    t_align();
    t_wmul();
    t_arith();
    summarize();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #250000;
    error_cnt++;
    summarize();
  end
endmodule
